// ===== common/rlc_pkg.sv
// package: register map, field layout, reset values and rate tables
// ****************************************************************
// What this block does
// [R1] Four enable bits switch automatic gain on channel 1 left, 1 right, 2 left, 2 right.
// [R2] Upper nibble bit 0 puts channel 1 and bit 2 puts channel 2 into analog-plus-digital gain, bits 1 and 3 reserved.
// [R3] The release code paces gain rises from 28.66 sample periods per dB doubling to code 1001, with 1010 to 1111 at 29348.
// [R4] The attack code paces gain falls from 7.33 sample periods per dB doubling to code 1011, with 1100 to 1111 at 30024.
// [R5] A release starts only after a hold of 62 sample periods doubled per code step, up to 2031616 at code 1111.
// [R6] Input below the six-bit noise threshold (0 dBFS minus 1.5 dB per code, reset -94.5 dBFS) changes no gain.
// [R7] Output below the six-bit minimum target (same encoding, reset -94.5 dBFS) makes the gain rise until it is above.
// [R8] Output above the six-bit maximum target (0 dBFS minus 1.5 dB per code) makes the gain fall until it is below.
// [R9] Total gain and total attenuation are capped separately by four-bit codes of 6 dB per step, both resetting to 90 dB.
// [R10] In hybrid mode the analog share stays between three-bit limits of 6 dB per step, code 001 being 0 dB.
// [R11] With clip prevention on, an over-target output falls at 0.034 dB per sample doubled per two-bit step code.
// [R12] Gain steps, hold counting and rate timing advance once per record sample period.
// ****************************************************************
package rlc_pkg;

  // ****************************************************************
  // register offsets
  // ****************************************************************
  localparam logic [7:0] OFS_ENABLES = 8'h30;
  localparam logic [7:0] OFS_RATES = 8'h31;
  localparam logic [7:0] OFS_HOLD = 8'h32;
  localparam logic [7:0] OFS_NOISE = 8'h33;
  localparam logic [7:0] OFS_TARGET_LOW = 8'h34;
  localparam logic [7:0] OFS_TARGET_HIGH = 8'h35;
  localparam logic [7:0] OFS_GAIN_CAPS = 8'h36;
  localparam logic [7:0] OFS_ANALOG_CAPS = 8'h37;
  localparam logic [7:0] OFS_CLIP_GUARD = 8'h38;
  // read-only gain status, one byte per channel side
  localparam logic [7:0] OFS_GAIN_STATUS0 = 8'h39;

  // ****************************************************************
  // reset values and writable-bit masks
  // ****************************************************************
  localparam logic [7:0] RST_ENABLES = 8'h00;
  localparam logic [7:0] RST_RATES = 8'h00;
  localparam logic [7:0] RST_HOLD = 8'h00;
  localparam logic [7:0] RST_NOISE = 8'h3F;
  localparam logic [7:0] RST_TARGET_LOW = 8'h3F;
  localparam logic [7:0] RST_TARGET_HIGH = 8'h00;
  localparam logic [7:0] RST_GAIN_CAPS = 8'hFF;
  localparam logic [7:0] RST_ANALOG_CAPS = 8'h71;
  localparam logic [7:0] RST_CLIP_GUARD = 8'h00;
  localparam logic [7:0] MSK_HOLD = 8'h0F;
  localparam logic [7:0] MSK_LEVEL = 8'h3F;
  localparam logic [7:0] MSK_ANALOG_CAPS = 8'h77;
  localparam logic [7:0] MSK_CLIP_GUARD = 8'h83;

  // ****************************************************************
  // field positions (lsb of each field)
  // ****************************************************************
  localparam int POS_ENABLE = 0;
  localparam int POS_HYBRID = 4;
  localparam int POS_ATTACK = 0;
  localparam int POS_RELEASE = 4;
  localparam int POS_ATTEN_CAP = 0;
  localparam int POS_GAIN_CAP = 4;
  localparam int POS_ANA_MIN = 0;
  localparam int POS_ANA_MAX = 4;
  localparam int POS_CLIP_STEP = 0;
  localparam int POS_CLIP_EN = 7;

  // ****************************************************************
  // gain units: one step is 1.5 dB, so 6 dB is four steps
  // ****************************************************************
  localparam logic signed [8:0] STEPS_PER_6DB = 9'sh004;
  localparam logic [2:0] ANA_CODE_0DB = 3'h1;
  localparam logic [2:0] ANA_MAX_LEGAL = 3'h5;

  // ****************************************************************
  // rate timing; periods are hundredths of a sample per dB
  // ****************************************************************
  localparam logic [3:0] REL_LAST = 4'hA;
  localparam logic [3:0] ATK_LAST = 4'hC;
  localparam logic [21:0] REL_PERIOD [0:10] = '{
    22'h000B32, 22'h001665, 22'h002CC4, 22'h005992, 22'h00B324,
    22'h01663E, 22'h02CC68, 22'h0598D0, 22'h0B3204, 22'h166408,
    22'h2CC810};
  localparam logic [21:0] ATK_PERIOD [0:12] = '{
    22'h0002DD, 22'h0005BA, 22'h000B74, 22'h0016E8, 22'h002DD2,
    22'h005BA4, 22'h00B73E, 22'h016E7C, 22'h02DCD0, 22'h05BA04,
    22'h0B7408, 22'h16E810, 22'h2DD020};
  // per sample the accumulator gains 2 x 100, the step costs 3 x period
  localparam logic [8:0] NORMAL_INC = 9'h0C8;
  // clip prevention runs in thousandths of a dB per sample
  localparam logic [8:0] CLIP_BASE_INC = 9'h022;
  localparam logic [23:0] CLIP_STEP_COST = 24'h0005DC;
  localparam logic [20:0] HOLD_BASE = 21'h00003E;

  typedef enum logic [3:0] {
    RLC_IDLE = 4'b0001,
    RLC_ATTACK = 4'b0010,
    RLC_HOLD = 4'b0100,
    RLC_RELEASE = 4'b1000
  } rlc_state_e;

endpackage

// ===== src/rlc_level_ctl.sv
// record-path automatic level control: registers and per-channel gain loop
`timescale 1ns/10ps
module rlc_level_ctl (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic sample_tick,
  input wire logic [3:0][5:0] in_level,
  output logic [3:0][7:0] total_gain,
  output logic [3:0][7:0] analog_gain,
  output logic [3:0][7:0] digital_gain,
  output logic [3:0] gain_active
);

  // ****************************************************************
  // register file
  // ****************************************************************
  logic [7:0] level_ctl_enables;
  logic [7:0] level_ctl_rates;
  logic [7:0] level_ctl_hold_time;
  logic [7:0] level_ctl_noise_gate;
  logic [7:0] level_ctl_target_low;
  logic [7:0] level_ctl_target_high;
  logic [7:0] level_ctl_gain_caps;
  logic [7:0] level_ctl_analog_caps;
  logic [7:0] level_ctl_clip_guard;
  logic signed [3:0][7:0] gain;

  wire wr_enables = wr && (addr == rlc_pkg::OFS_ENABLES);
  wire wr_rates = wr && (addr == rlc_pkg::OFS_RATES);
  wire wr_hold = wr && (addr == rlc_pkg::OFS_HOLD);
  wire wr_noise = wr && (addr == rlc_pkg::OFS_NOISE);
  wire wr_tlow = wr && (addr == rlc_pkg::OFS_TARGET_LOW);
  wire wr_thigh = wr && (addr == rlc_pkg::OFS_TARGET_HIGH);
  wire wr_gcaps = wr && (addr == rlc_pkg::OFS_GAIN_CAPS);
  wire wr_acaps = wr && (addr == rlc_pkg::OFS_ANALOG_CAPS);
  wire wr_clip = wr && (addr == rlc_pkg::OFS_CLIP_GUARD);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_enables <= rlc_pkg::RST_ENABLES;
    end else if (wr_enables) begin
      level_ctl_enables <= wdata; // [R1] [R2]
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_rates <= rlc_pkg::RST_RATES;
    end else if (wr_rates) begin
      level_ctl_rates <= wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_hold_time <= rlc_pkg::RST_HOLD;
    end else if (wr_hold) begin
      level_ctl_hold_time <= wdata & rlc_pkg::MSK_HOLD;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_noise_gate <= rlc_pkg::RST_NOISE;
    end else if (wr_noise) begin
      level_ctl_noise_gate <= wdata & rlc_pkg::MSK_LEVEL;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_target_low <= rlc_pkg::RST_TARGET_LOW;
    end else if (wr_tlow) begin
      level_ctl_target_low <= wdata & rlc_pkg::MSK_LEVEL;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_target_high <= rlc_pkg::RST_TARGET_HIGH;
    end else if (wr_thigh) begin
      level_ctl_target_high <= wdata & rlc_pkg::MSK_LEVEL;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_gain_caps <= rlc_pkg::RST_GAIN_CAPS;
    end else if (wr_gcaps) begin
      level_ctl_gain_caps <= wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_analog_caps <= rlc_pkg::RST_ANALOG_CAPS;
    end else if (wr_acaps) begin
      level_ctl_analog_caps <= wdata & rlc_pkg::MSK_ANALOG_CAPS;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      level_ctl_clip_guard <= rlc_pkg::RST_CLIP_GUARD;
    end else if (wr_clip) begin
      level_ctl_clip_guard <= wdata & rlc_pkg::MSK_CLIP_GUARD;
    end
  end

  // ****************************************************************
  // read port: data stand in the cycle after the strobe only
  // ****************************************************************
  wire [7:0] status_idx = addr - rlc_pkg::OFS_GAIN_STATUS0;
  wire is_status = (addr >= rlc_pkg::OFS_GAIN_STATUS0) &&
                   (status_idx < 8'h04);
  logic [7:0] read_mux;

  always_comb begin
    read_mux = 8'h00;
    unique case (addr)
      rlc_pkg::OFS_ENABLES: read_mux = level_ctl_enables;
      rlc_pkg::OFS_RATES: read_mux = level_ctl_rates;
      rlc_pkg::OFS_HOLD: read_mux = level_ctl_hold_time;
      rlc_pkg::OFS_NOISE: read_mux = level_ctl_noise_gate;
      rlc_pkg::OFS_TARGET_LOW: read_mux = level_ctl_target_low;
      rlc_pkg::OFS_TARGET_HIGH: read_mux = level_ctl_target_high;
      rlc_pkg::OFS_GAIN_CAPS: read_mux = level_ctl_gain_caps;
      rlc_pkg::OFS_ANALOG_CAPS: read_mux = level_ctl_analog_caps;
      rlc_pkg::OFS_CLIP_GUARD: read_mux = level_ctl_clip_guard;
      default: begin
        if (is_status) read_mux = gain[status_idx[1:0]];
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? read_mux : 8'h00;
    end
  end

  // ****************************************************************
  // shared decode
  // ****************************************************************
  function automatic logic [23:0] step_cost(input logic [3:0] code,
                                            input logic attack);
    logic [3:0] idx;
    idx = 4'h0;
    if (attack) begin
      idx = (code > rlc_pkg::ATK_LAST) ? rlc_pkg::ATK_LAST : code;
      step_cost = 24'(rlc_pkg::ATK_PERIOD[idx] * 3);
    end else begin
      idx = (code > rlc_pkg::REL_LAST) ? rlc_pkg::REL_LAST : code;
      step_cost = 24'(rlc_pkg::REL_PERIOD[idx] * 3);
    end
  endfunction

  // analog limit code to 1.5 dB steps; code 000 goes to 001, codes above 101 go to 101 for the maximum only
  function automatic logic signed [8:0] ana_steps(input logic [2:0] code,
                                                  input logic is_max);
    logic [2:0] c;
    c = (code < rlc_pkg::ANA_CODE_0DB) ? rlc_pkg::ANA_CODE_0DB : code;
    if (is_max && c > rlc_pkg::ANA_MAX_LEGAL) c = rlc_pkg::ANA_MAX_LEGAL;
    ana_steps = 9'($signed({6'h00, c - rlc_pkg::ANA_CODE_0DB}) *
                   rlc_pkg::STEPS_PER_6DB);
  endfunction

  wire [3:0] rel_code = level_ctl_rates[rlc_pkg::POS_RELEASE +: 4];
  wire [3:0] atk_code = level_ctl_rates[rlc_pkg::POS_ATTACK +: 4];
  wire [23:0] rel_cost = step_cost(rel_code, 1'b0); // [R3]
  wire [23:0] atk_cost = step_cost(atk_code, 1'b1); // [R4]
  wire [20:0] hold_len =
    rlc_pkg::HOLD_BASE << level_ctl_hold_time[3:0]; // [R5]
  wire clip_on = level_ctl_clip_guard[rlc_pkg::POS_CLIP_EN];
  wire [1:0] clip_step = level_ctl_clip_guard[rlc_pkg::POS_CLIP_STEP +: 2];
  wire [8:0] clip_inc = rlc_pkg::CLIP_BASE_INC << clip_step; // [R11]
  wire [3:0] gain_cap_code = level_ctl_gain_caps[rlc_pkg::POS_GAIN_CAP +: 4];
  wire [3:0] att_cap_code = level_ctl_gain_caps[rlc_pkg::POS_ATTEN_CAP +: 4];
  wire signed [8:0] gain_cap =
    9'($signed({5'h00, gain_cap_code}) * rlc_pkg::STEPS_PER_6DB); // [R9]
  wire signed [8:0] att_cap =
    9'(-($signed({5'h00, att_cap_code}) * rlc_pkg::STEPS_PER_6DB)); // [R9]
  wire signed [8:0] ana_lo =
    ana_steps(level_ctl_analog_caps[rlc_pkg::POS_ANA_MIN +: 3], 1'b0);
  wire signed [8:0] ana_hi =
    ana_steps(level_ctl_analog_caps[rlc_pkg::POS_ANA_MAX +: 3], 1'b1);
  wire signed [8:0] noise_thr = $signed({3'h0, level_ctl_noise_gate[5:0]});
  wire signed [8:0] low_thr = $signed({3'h0, level_ctl_target_low[5:0]});
  wire signed [8:0] high_thr = $signed({3'h0, level_ctl_target_high[5:0]});

  // ****************************************************************
  // per-channel gain loop; level codes grow as the signal gets quieter
  // ****************************************************************
  for (genvar ch = 0; ch < 4; ch++) begin : g_chan
    rlc_pkg::rlc_state_e state;
    rlc_pkg::rlc_state_e next_state;
    logic [23:0] acc;
    logic [20:0] hold_cnt;
    logic signed [8:0] next_gain;
    logic [23:0] next_acc;
    logic signed [8:0] ana;

    wire enabled = level_ctl_enables[rlc_pkg::POS_ENABLE + ch]; // [R1]
    wire hybrid =
      level_ctl_enables[rlc_pkg::POS_HYBRID + (ch / 2) * 2]; // [R2]
    wire signed [8:0] g = 9'($signed(gain[ch]));
    wire signed [8:0] in_code = $signed({3'h0, in_level[ch]});
    wire signed [8:0] out_code = in_code - g;
    wire gated = in_code > noise_thr; // [R6]
    wire too_loud = out_code < high_thr; // [R8]
    wire too_quiet = out_code > low_thr; // [R7]
    wire hold_done = hold_cnt >= hold_len; // [R5]
    wire fast = clip_on && too_loud; // [R11]
    wire [23:0] cost = (state == rlc_pkg::RLC_ATTACK) ?
      (fast ? rlc_pkg::CLIP_STEP_COST : atk_cost) : rel_cost;
    wire [23:0] inc = fast ? {15'h0000, clip_inc} :
                             {15'h0000, rlc_pkg::NORMAL_INC};
    wire [23:0] acc_sum = acc + inc;
    wire step_due = acc_sum >= cost;

    always_comb begin
      next_state = rlc_pkg::RLC_IDLE;
      if (enabled && !gated) begin // [R6]
        if (too_loud) begin
          next_state = rlc_pkg::RLC_ATTACK; // [R8]
        end else if (too_quiet) begin
          next_state = ((state == rlc_pkg::RLC_HOLD && hold_done) ||
                        state == rlc_pkg::RLC_RELEASE) ?
                       rlc_pkg::RLC_RELEASE : rlc_pkg::RLC_HOLD; // [R5] [R7]
        end
      end
    end

    always_comb begin
      next_gain = g;
      next_acc = 24'h000000;
      unique case (state)
        rlc_pkg::RLC_ATTACK: begin
          next_acc = step_due ? acc_sum - cost : acc_sum; // [R4] [R11]
          if (step_due && g > att_cap) next_gain = g - 9'sh001; // [R9]
        end
        rlc_pkg::RLC_RELEASE: begin
          next_acc = step_due ? acc_sum - cost : acc_sum; // [R3]
          if (step_due && g < gain_cap) next_gain = g + 9'sh001; // [R9]
        end
        rlc_pkg::RLC_IDLE, rlc_pkg::RLC_HOLD: next_acc = 24'h000000;
      endcase
      // a cap lowered by software pulls the gain back at once
      if (next_gain > gain_cap) next_gain = gain_cap; // [R9]
      if (next_gain < att_cap) next_gain = att_cap; // [R9]
      if (!enabled) next_gain = 9'sh000;
    end

    // the analog share is clamped, the digital stage takes the rest
    always_comb begin
      ana = 9'sh000;
      if (hybrid) begin // [R10]
        ana = g;
        if (ana > ana_hi) ana = ana_hi; // [R10]
        if (ana < ana_lo) ana = ana_lo; // [R10]
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        state <= rlc_pkg::RLC_IDLE;
        acc <= 24'h000000;
        hold_cnt <= 21'h000000;
        gain[ch] <= 8'sh00;
      end else if (sample_tick) begin // [R12]
        state <= next_state;
        acc <= (next_state == state) ? next_acc : 24'h000000;
        // any exit from hold restarts the count, so no stale time is kept
        hold_cnt <= (state == rlc_pkg::RLC_HOLD &&
                     next_state == rlc_pkg::RLC_HOLD) ?
                    hold_cnt + 21'h000001 : 21'h000000; // [R5]
        gain[ch] <= 8'(next_gain);
      end else if (!enabled) begin
        state <= rlc_pkg::RLC_IDLE;
        gain[ch] <= 8'sh00;
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        total_gain[ch] <= 8'h00;
        analog_gain[ch] <= 8'h00;
        digital_gain[ch] <= 8'h00;
        gain_active[ch] <= 1'b0;
      end else begin
        total_gain[ch] <= gain[ch];
        analog_gain[ch] <= 8'(ana);
        digital_gain[ch] <= 8'(g - ana); // [R10]
        gain_active[ch] <= (state == rlc_pkg::RLC_ATTACK) ||
                           (state == rlc_pkg::RLC_RELEASE);
      end
    end
  end

endmodule

// ===== test/rlc_level_ctl_props.sv
// checker: port-level timing and value relations of the level control
`timescale 1ns/10ps
module rlc_level_ctl_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic sample_tick,
  input wire logic [3:0][5:0] in_level,
  input wire logic [3:0][7:0] total_gain,
  input wire logic [3:0][7:0] analog_gain,
  input wire logic [3:0][7:0] digital_gain,
  input wire logic [3:0] gain_active
);
  // ****************************************************************
  // shadow copies of the registers the checks depend on
  // ****************************************************************
  logic [7:0] en_sh;
  logic [5:0] noise_sh;
  wire gated = en_sh[0] && (in_level[0] > noise_sh);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      en_sh <= 8'h00;
      noise_sh <= 6'h3F;
    end else if (wr) begin
      if (addr == rlc_pkg::OFS_ENABLES) en_sh <= wdata;
      if (addr == rlc_pkg::OFS_NOISE) noise_sh <= wdata[5:0];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  // ****************************************************************
  // assertions
  // ****************************************************************
  rdata_idle_a: assert property ($past(!rd) |-> rdata == 8'h00)
    else $error("read data not idle");
  en_readback_a: assert property (
    $past(rd && addr == rlc_pkg::OFS_ENABLES) |-> rdata == $past(en_sh))
    else $error("enable readback wrong");
  split_sum_a: assert property (
    digital_gain[0] == total_gain[0] - analog_gain[0])
    else $error("gain split wrong");
  ana_off_a: assert property (
    $past(!en_sh[4], 3) && $past(!en_sh[4], 2) && $past(!en_sh[4])
    |-> analog_gain[0] == 8'h00)
    else $error("analog share outside hybrid");
  off_zero_a: assert property (
    $past(!en_sh[0], 2) |-> total_gain[0] == 8'h00 && !gain_active[0])
    else $error("disabled side moves");
  gain_range_a: assert property (
    $signed(total_gain[0]) <= 60 && $signed(total_gain[0]) >= -60)
    else $error("gain past cap");
  gate_idle_a: assert property (
    (gated && sample_tick) ##1 gated [*2] |-> !gain_active[0])
    else $error("gated side active");
  // release needs at least 43 ticks per step, so 8 clocks is safe
  rise_pace_a: assert property (
    $signed($past(total_gain[0])) >= 0 &&
    $signed(total_gain[0]) > $signed($past(total_gain[0])) |=>
    ($signed(total_gain[0]) <= $signed($past(total_gain[0]))) [*8])
    else $error("gain rises too fast");
  // the fastest clip step still leaves five ticks between falls
  fall_pace_a: assert property (
    $signed($past(total_gain[0])) <= 0 &&
    $signed(total_gain[0]) < $signed($past(total_gain[0])) |=>
    ($signed(total_gain[0]) >= $signed($past(total_gain[0]))) [*4])
    else $error("gain falls too fast");
endmodule
bind rlc_level_ctl rlc_level_ctl_props u_props (.clk(clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .sample_tick(sample_tick), .in_level(in_level), .total_gain(total_gain),
  .analog_gain(analog_gain), .digital_gain(digital_gain),
  .gain_active(gain_active));

// ===== test/rlc_adc_src.sv
// record path model: sample pacing and one input level copied to all four sides
`timescale 1ns/10ps
module rlc_adc_src (
  input wire logic clk,
  input wire logic reset,
  input wire logic run,
  input wire logic [5:0] level,
  output logic sample_tick,
  output logic [3:0][5:0] in_level
);
  // one tick per record sample; a tick every clock keeps runs short
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sample_tick <= 1'b0;
      in_level <= '1;
    end else begin
      sample_tick <= run;
      in_level <= {4{level}};
    end
  end
endmodule

// ===== test/tb.sv
// self-checking bench for the record level control
`timescale 1ns/10ps
module tb;
  logic clk, reset, wr, rd, run, sample_tick;
  logic [7:0] addr, wdata, rdata;
  logic [5:0] level;
  logic [3:0][5:0] in_level;
  logic [3:0][7:0] total_gain, analog_gain, digital_gain;
  logic [3:0] gain_active;
  int mismatches, checks_done;
  rlc_level_ctl u_dut (.clk(clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .sample_tick(sample_tick), .in_level(in_level),
    .total_gain(total_gain), .analog_gain(analog_gain),
    .digital_gain(digital_gain), .gain_active(gain_active));
  rlc_adc_src u_src (.clk(clk), .reset(reset), .run(run), .level(level),
    .sample_tick(sample_tick), .in_level(in_level));
  initial begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wreg(input logic [7:0] a, d);
    @(posedge clk);
    wr <= 1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
  endtask
  task automatic rchk(input string what, input logic [7:0] a, exp);
    @(posedge clk);
    rd <= 1;
    addr <= a;
    @(posedge clk);
    rd <= 0;
    #1 chk(what, rdata, exp);
  endtask
  task automatic ticks(input int n);
    @(posedge clk);
    run <= 1;
    repeat (n) @(posedge clk);
    run <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset;
    logic [7:0] rv [9] = '{8'h00, 8'h00, 8'h00, 8'h3F, 8'h3F, 8'h00,
      8'hFF, 8'h71, 8'h00};
    for (int i = 0; i < 9; i++) begin
      rchk("reset value", 8'h30 + i[7:0], rv[i]);
    end
    rchk("unmapped", 8'h3D, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_masks;
    logic [7:0] ra [5] = '{8'h31, 8'h32, 8'h33, 8'h37, 8'h38};
    logic [7:0] rm [5] = '{8'hFF, 8'h0F, 8'h3F, 8'h77, 8'h83};
    for (int i = 0; i < 5; i++) begin
      wreg(ra[i], 8'hFF);
      rchk("masked field", ra[i], rm[i]);
    end
    wreg(8'h39, 8'h55);
    rchk("status", 8'h39, 8'h00);
    wreg(8'h31, 8'h00);
    wreg(8'h32, 8'h00);
    wreg(8'h38, 8'h00);
    $display("test masks done");
  endtask
  task automatic t_attack;
    level <= 6'h00;
    wreg(8'h35, 8'h0A);
    wreg(8'h30, 8'h01);
    ticks(40);
    // 7.33 samples per dB: one 1.5 dB step per 11 samples, three in 40
    chk("attack gain", total_gain[0], 8'hFD);
    chk("attack active", {7'h00, gain_active[0]}, 8'h01);
    chk("other side", total_gain[1], 8'h00);
    wreg(8'h36, 8'hF0);
    ticks(3);
    chk("atten cap", total_gain[0], 8'h00);
    wreg(8'h36, 8'hFF);
    wreg(8'h30, 8'h00);
    $display("test attack done");
  endtask
  task automatic t_clip;
    // step 3 gives 0.272 dB per sample: seven 1.5 dB steps in 40 samples
    wreg(8'h38, 8'h83);
    wreg(8'h30, 8'h01);
    ticks(40);
    chk("clip gain", total_gain[0], 8'hF9);
    wreg(8'h38, 8'h00);
    wreg(8'h30, 8'h00);
    $display("test clip done");
  endtask
  task automatic t_noise;
    level <= 6'h14;
    wreg(8'h33, 8'h05);
    wreg(8'h35, 8'h00);
    wreg(8'h34, 8'h0A);
    wreg(8'h30, 8'h01);
    ticks(200);
    chk("gated gain", total_gain[0], 8'h00);
    chk("gated active", {7'h00, gain_active[0]}, 8'h00);
    wreg(8'h33, 8'h3F);
    $display("test noise done");
  endtask
  task automatic t_release;
    wreg(8'h37, 8'h21);
    wreg(8'h30, 8'h11);
    ticks(50);
    chk("hold gain", total_gain[0], 8'h00);
    chk("hold active", {7'h00, gain_active[0]}, 8'h00);
    ticks(50);
    chk("release wait", total_gain[0], 8'h00);
    chk("release active", {7'h00, gain_active[0]}, 8'h01);
    ticks(15);
    chk("release step", total_gain[0], 8'h01);
    chk("analog share", analog_gain[0], 8'h01);
    chk("digital share", digital_gain[0], 8'h00);
    wreg(8'h36, 8'h0F);
    ticks(3);
    chk("gain cap", total_gain[0], 8'h00);
    wreg(8'h30, 8'h00);
    repeat (3) @(posedge clk);
    #1 chk("disabled", {7'h00, gain_active[0]}, 8'h00);
    $display("test release done");
  endtask
  initial begin
    reset = 1;
    {wr, rd, run, addr, wdata} = '0;
    level = 6'h3F;
    mismatches = 0;
    checks_done = 0;
    repeat (20) @(posedge clk);
    reset <= 0;
    t_reset;
    t_masks;
    t_attack;
    t_clip;
    t_noise;
    t_release;
    print_verdict;
  end
  // the tests take about 550 clocks; a hang is cut well after that
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    print_verdict;
  end
endmodule
